// file: pcie_link_control_upper_bits_tb_top.sv
/*
  Self-checking bench for the link control block over APB.
  Assumes the training model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "plcub_regs.svh"

module pcie_link_control_upper_bits_tb_top;
  import plcub_pkg::*;
  localparam plcub_addr_t LC = `PLCUB_LINK_CONTROL_OFS;
  localparam plcub_addr_t LS = `PLCUB_LINK_STATUS_OFS;
  logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic up_pin = 1'b0, cap_pin = 1'b1, slow = 1'b0, abw_cmd = 1'b0, down_cmd = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  plcub_addr_t paddr = '0;
  logic pready, pslverr, rec, cfg, dl_down, abw, rreq, ccf, esy, tip, bw_irq, err;
  int fail_count = 0, samples_checked = 0, cyc = 0;

  always #5 clock = ~clock;

  plcub_top u_plcub_top (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .upstream_port_pin(up_pin),
    .bw_notify_capable_pin(cap_pin), .ltssm_in_recovery(rec), .ltssm_in_config(cfg),
    .dl_down(dl_down), .autonomous_bw_change(abw), .retrain_req(rreq),
    .common_refclk_flag(ccf), .extended_sync_enable(esy), .training_in_progress(tip),
    .bw_irq(bw_irq));

  plcub_ltssm_model u_plcub_ltssm_model (.clock(clock), .rst_b(rst_b), .retrain_req(rreq),
    .slow(slow), .abw_cmd(abw_cmd), .down_cmd(down_cmd), .in_rec(rec), .in_cfg(cfg),
    .dl_down(dl_down), .abw_pulse(abw));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input plcub_addr_t a, input logic [15:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_on(input logic want_rec);
    int n;
    n = 0;
    while ((want_rec ? rec !== 1'b1 : tip !== 1'b0) && n < 60) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, n < 60}, 32'h1);
  endtask : wait_on

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_retrain;
    apb(0, LC, 16'h0000); chk(q, 32'h0);
    apb(1, LC, 16'hffff);
    #1;
    chk({rreq, tip, ccf, esy}, 4'hf);
    apb(0, LC, 16'h0000); chk(q, 32'h0cc0);
    wait_on(1'b0);
    apb(0, LS, 16'h0000); chk(q, 32'h4000);
    chk(bw_irq, 1'b1);
    apb(1, LS, 16'h4000);
    @(posedge clock);
    #1;
    chk(bw_irq, 1'b0);
    $display("retrain test done");
  endtask : t_retrain

  task t_abw;
    @(posedge clock);
    abw_cmd <= 1'b1;
    @(posedge clock);
    abw_cmd <= 1'b0;
    apb(0, LS, 16'h0000); chk(q, 32'h8000);
    chk(bw_irq, 1'b1);
    apb(1, LC, 16'h0000);
    @(posedge clock);
    #1;
    chk(bw_irq, 1'b0);
    apb(1, LS, 16'h8000);
    $display("autonomous test done");
  endtask : t_abw

  task t_pending;
    @(posedge clock);
    slow <= 1'b1;
    down_cmd <= 1'b1;
    apb(1, LC, 16'h00e0);
    wait_on(1'b1);
    apb(1, LC, 16'h0020);
    #1;
    chk({ccf, esy}, 2'b11);
    apb(0, LC, 16'h0000); chk(q, 32'h0);
    wait_on(1'b0);
    chk({ccf, esy}, 2'b11);
    apb(0, LS, 16'h0000); chk(q, 32'h0);
    wait_on(1'b1);
    #1;
    chk({ccf, esy}, 2'b00);
    wait_on(1'b0);
    apb(1, LC, 16'h0060);
    #1;
    chk({ccf, esy}, 2'b10);
    wait_on(1'b0);
    $display("pending test done");
  endtask : t_pending

  task t_straps;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      cap_pin <= i[0];
      up_pin <= i[0];
      repeat (4) @(posedge clock);
      apb(1, LC, 16'h0c00);
      apb(0, LC, 16'h0000); chk(q, 32'h0);
    end
    @(posedge clock);
    up_pin <= 1'b0;
    apb(0, 12'h060, 16'h0000);
    chk(err, 1'b1);
    chk(q, 32'h0);
    $display("strap test done");
  endtask : t_straps

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      test_done;
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    t_retrain;
    t_abw;
    t_pending;
    t_straps;
    test_done;
  end
endmodule : pcie_link_control_upper_bits_tb_top

`default_nettype wire

// file: plcub_ltssm_model.sv
/*
  Behavioural training state machine for the link side of the block.
  Assumes the bench steers its pace, link-down level and speed changes.
*/
`timescale 1ns/100ps
`default_nettype none

module plcub_ltssm_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Commands
  input wire logic retrain_req,
  input wire logic slow,
  input wire logic abw_cmd,
  input wire logic down_cmd,
  // State reports
  output logic in_rec,
  output logic in_cfg,
  output logic dl_down,
  output logic abw_pulse
);
  logic [3:0] cnt_r;

  // ----------------------------------------------------------------
  // Training pass: wait, Recovery, Configuration, back to L0
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
    end else if (retrain_req) begin
      cnt_r <= slow ? 4'hf : 4'h5;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_rec <= 1'b0;
      in_cfg <= 1'b0;
      dl_down <= 1'b0;
      abw_pulse <= 1'b0;
    end else begin
      in_rec <= cnt_r > 4'h2 && cnt_r < 4'h9;
      in_cfg <= cnt_r == 4'h2;
      dl_down <= down_cmd;
      abw_pulse <= abw_cmd;
    end
  end
endmodule : plcub_ltssm_model

`default_nettype wire

// file: plcub_pkg.sv
/*
  Types for the link control upper bits block.
  Assumes nothing beyond the register header.
*/
`include "plcub_regs.svh"

package plcub_pkg;

  // ----------------------------------------------------------------
  // Retrain tracking states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLCUB_RT_IDLE = 2'b00,
    PLCUB_RT_WAIT = 2'b01,
    PLCUB_RT_TRAIN = 2'b10
  } plcub_rt_state_t;

  typedef logic [`PLCUB_ADDR_W-1:0] plcub_addr_t;

endpackage : plcub_pkg

// file: plcub_regs.svh
/*
  Register offsets, field positions, reset values and timing counts
  for the link control upper bits block.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef PLCUB_REGS_SVH
`define PLCUB_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define PLCUB_ADDR_W 12
`define PLCUB_LINK_CONTROL_OFS 12'h050
`define PLCUB_LINK_STATUS_OFS 12'h054

// ----------------------------------------------------------------
// Link control fields
// ----------------------------------------------------------------
`define PLCUB_LC_RETRAIN_BIT 5
`define PLCUB_LC_COMMON_CLK_BIT 6
`define PLCUB_LC_EXT_SYNC_BIT 7
`define PLCUB_LC_CLOCK_PM_BIT 8
`define PLCUB_LC_AUTO_WIDTH_BIT 9
`define PLCUB_LC_BW_IRQ_EN_BIT 10
`define PLCUB_LC_ABW_IRQ_EN_BIT 11

// ----------------------------------------------------------------
// Link status fields
// ----------------------------------------------------------------
`define PLCUB_LS_TRAINING_BIT 11
`define PLCUB_LS_BW_STS_BIT 14
`define PLCUB_LS_ABW_STS_BIT 15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PLCUB_COMMON_CLK_RST 1'h0
`define PLCUB_EXT_SYNC_RST 1'h0
`define PLCUB_IRQ_EN_RST 1'h0
`define PLCUB_STS_RST 1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PLCUB_SYNC_STAGES 2

`endif

// file: plcub_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module plcub_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Per-bit two-stage chain
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          hold_r <= meta_r;
        end
      end
      assign sync_out[i] = hold_r;
    end
  endgenerate

endmodule : plcub_sync

`default_nettype wire

// file: plcub_top.sv
/*
  Upper bits of the link control register of a switch port, with the
  bandwidth status bits and the interrupt they raise, behind APB.
  Assumes the training state machine runs on the same clock and reports
  its Recovery and Configuration states as levels; port-type and
  bandwidth-notification straps arrive as pins.
*/
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "plcub_regs.svh"

module plcub_top
  import plcub_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PLCUB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps from pins
  input wire logic upstream_port_pin,
  input wire logic bw_notify_capable_pin,
  // Training state machine side
  input wire logic ltssm_in_recovery,
  input wire logic ltssm_in_config,
  input wire logic dl_down,
  input wire logic autonomous_bw_change,
  output logic retrain_req,
  output logic common_refclk_flag,
  output logic extended_sync_enable,
  output logic training_in_progress,
  // Interrupt
  output logic bw_irq
);

  // ----------------------------------------------------------------
  // Strap synchronisation
  // ----------------------------------------------------------------
  logic [1:0] strap_s;
  logic upstream_s;
  logic bw_notify_capable;
  logic bw_cap;
  plcub_sync #(.W(2)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({bw_notify_capable_pin, upstream_port_pin}),
    .sync_out(strap_s)
  );
  assign upstream_s = strap_s[0];
  assign bw_notify_capable = strap_s[1];
  assign bw_cap = bw_notify_capable & ~upstream_s;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic hit_lc;
  logic hit_ls;
  logic wr_lc;
  logic wr_ls;
  logic retrain_wr;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_lc = (paddr == `PLCUB_LINK_CONTROL_OFS);
  assign hit_ls = (paddr == `PLCUB_LINK_STATUS_OFS);
  assign pready = 1'b1;
  assign pslverr = access_ph & ~(hit_lc | hit_ls);
  assign wr_lc = access_ph & pwrite & hit_lc;
  assign wr_ls = access_ph & pwrite & hit_ls;
  assign retrain_wr = wr_lc & pstrb[0] & pwdata[`PLCUB_LC_RETRAIN_BIT];

  // ----------------------------------------------------------------
  // Training state tracking
  // ----------------------------------------------------------------
  logic in_train;
  logic in_train_prev_r;
  logic train_enter;
  logic train_exit;
  assign in_train = ltssm_in_recovery | ltssm_in_config;
  assign train_enter = in_train & ~in_train_prev_r;
  assign train_exit = ~in_train & in_train_prev_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_train_prev_r <= 1'b0;
    end else begin
      in_train_prev_r <= in_train;
    end
  end

  // ----------------------------------------------------------------
  // Retrain request pulse
  // ----------------------------------------------------------------
  logic retrain_req_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      retrain_req_r <= 1'b0;
    end else begin
      retrain_req_r <= retrain_wr;
    end
  end
  assign retrain_req = retrain_req_r;

  // ----------------------------------------------------------------
  // Staged software fields
  // ----------------------------------------------------------------
  logic common_clk_r;
  logic ext_sync_r;
  logic bw_irq_en_r;
  logic abw_irq_en_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      common_clk_r <= `PLCUB_COMMON_CLK_RST;
      ext_sync_r <= `PLCUB_EXT_SYNC_RST;
    end else if (wr_lc && pstrb[0]) begin
      common_clk_r <= pwdata[`PLCUB_LC_COMMON_CLK_BIT];
      ext_sync_r <= pwdata[`PLCUB_LC_EXT_SYNC_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bw_irq_en_r <= `PLCUB_IRQ_EN_RST;
      abw_irq_en_r <= `PLCUB_IRQ_EN_RST;
    end else if (!bw_cap) begin
      bw_irq_en_r <= 1'b0;
      abw_irq_en_r <= 1'b0;
    end else if (wr_lc && pstrb[1]) begin
      bw_irq_en_r <= pwdata[`PLCUB_LC_BW_IRQ_EN_BIT];
      abw_irq_en_r <= pwdata[`PLCUB_LC_ABW_IRQ_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Applied fields toward the physical layer
  // ----------------------------------------------------------------
  logic apply_pend_r;
  logic applied_cc_r;
  logic applied_es_r;
  logic apply_now;
  logic apply_late;

  // Changes land at once outside training, else at the next entry
  assign apply_now = wr_lc & pstrb[0] & ~in_train;
  assign apply_late = apply_pend_r & train_enter & ~wr_lc;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      apply_pend_r <= 1'b0;
    end else if (wr_lc && pstrb[0] && in_train) begin
      apply_pend_r <= 1'b1;
    end else if (apply_late || apply_now) begin
      apply_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      applied_cc_r <= `PLCUB_COMMON_CLK_RST;
      applied_es_r <= `PLCUB_EXT_SYNC_RST;
    end else if (apply_now) begin
      applied_cc_r <= pwdata[`PLCUB_LC_COMMON_CLK_BIT];
      applied_es_r <= pwdata[`PLCUB_LC_EXT_SYNC_BIT];
    end else if (apply_late) begin
      applied_cc_r <= common_clk_r;
      applied_es_r <= ext_sync_r;
    end
  end

  // Exit latencies are reported elsewhere and do not follow this flag
  assign common_refclk_flag = applied_cc_r;
  assign extended_sync_enable = applied_es_r;

  // ----------------------------------------------------------------
  // Retrain tracking
  // ----------------------------------------------------------------
  plcub_rt_state_t rt_state_r;
  logic dl_down_seen_r;
  logic rt_done_ok;

  assign rt_done_ok = (rt_state_r == PLCUB_RT_TRAIN) & train_exit & ~dl_down_seen_r & ~dl_down;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rt_state_r <= PLCUB_RT_IDLE;
    end else if (retrain_wr) begin
      rt_state_r <= PLCUB_RT_WAIT;
    end else begin
      unique case (rt_state_r)
        PLCUB_RT_IDLE: rt_state_r <= PLCUB_RT_IDLE;
        PLCUB_RT_WAIT: begin
          if (in_train) begin
            rt_state_r <= PLCUB_RT_TRAIN;
          end
        end
        PLCUB_RT_TRAIN: begin
          if (train_exit) begin
            rt_state_r <= PLCUB_RT_IDLE;
          end
        end
        default: rt_state_r <= PLCUB_RT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dl_down_seen_r <= 1'b0;
    end else if (retrain_wr) begin
      dl_down_seen_r <= dl_down;
    end else if (rt_state_r != PLCUB_RT_IDLE && dl_down) begin
      dl_down_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Training in progress
  // ----------------------------------------------------------------
  logic tip_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tip_r <= 1'b0;
    end else if (retrain_wr) begin
      tip_r <= 1'b1;
    end else if (train_exit) begin
      tip_r <= 1'b0;
    end
  end
  assign training_in_progress = ~upstream_s & (tip_r | in_train);

  // ----------------------------------------------------------------
  // Bandwidth status bits, write one to clear, set wins
  // ----------------------------------------------------------------
  logic bw_sts_r;
  logic abw_sts_r;
  logic bw_clr;
  logic abw_clr;
  assign bw_clr = wr_ls & pstrb[1] & pwdata[`PLCUB_LS_BW_STS_BIT];
  assign abw_clr = wr_ls & pstrb[1] & pwdata[`PLCUB_LS_ABW_STS_BIT];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bw_sts_r <= `PLCUB_STS_RST;
    end else if (!bw_cap) begin
      bw_sts_r <= 1'b0;
    end else if (rt_done_ok) begin
      bw_sts_r <= 1'b1;
    end else if (bw_clr) begin
      bw_sts_r <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      abw_sts_r <= `PLCUB_STS_RST;
    end else if (!bw_cap) begin
      abw_sts_r <= 1'b0;
    end else if (autonomous_bw_change) begin
      abw_sts_r <= 1'b1;
    end else if (abw_clr) begin
      abw_sts_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic bw_irq_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bw_irq_r <= 1'b0;
    end else begin
      bw_irq_r <= (bw_sts_r & bw_irq_en_r) | (abw_sts_r & abw_irq_en_r);
    end
  end
  assign bw_irq = bw_irq_r;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] lc_view;
  logic [15:0] ls_view;
  logic [31:0] prdata_r;
  always_comb begin
    lc_view = 16'h0000;
    lc_view[`PLCUB_LC_RETRAIN_BIT] = 1'b0;
    lc_view[`PLCUB_LC_COMMON_CLK_BIT] = common_clk_r;
    lc_view[`PLCUB_LC_EXT_SYNC_BIT] = ext_sync_r;
    lc_view[`PLCUB_LC_CLOCK_PM_BIT] = 1'b0;
    lc_view[`PLCUB_LC_AUTO_WIDTH_BIT] = 1'b0;
    lc_view[`PLCUB_LC_BW_IRQ_EN_BIT] = bw_irq_en_r & bw_cap;
    lc_view[`PLCUB_LC_ABW_IRQ_EN_BIT] = abw_irq_en_r & bw_cap;
  end
  always_comb begin
    ls_view = 16'h0000;
    ls_view[`PLCUB_LS_TRAINING_BIT] = training_in_progress;
    ls_view[`PLCUB_LS_BW_STS_BIT] = bw_sts_r;
    ls_view[`PLCUB_LS_ABW_STS_BIT] = abw_sts_r;
  end
  // Unmapped reads return zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= {16'h0000, (hit_lc ? lc_view : 16'h0000) | (hit_ls ? ls_view : 16'h0000)};
    end
  end
  assign prdata = prdata_r;

endmodule : plcub_top

`default_nettype wire

// file: plcub_top_asserts.sv
/*
  Concurrent checks on the ports of the link control block.
  Assumes it is bound to every instance of the top module.
*/
`timescale 1ns/100ps
`default_nettype none
`include "plcub_regs.svh"

module plcub_top_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PLCUB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Straps and link side
  input wire logic upstream_port_pin,
  input wire logic bw_notify_capable_pin,
  input wire logic ltssm_in_recovery,
  input wire logic ltssm_in_config,
  input wire logic retrain_req,
  input wire logic common_refclk_flag,
  input wire logic extended_sync_enable,
  input wire logic training_in_progress,
  input wire logic bw_irq
);
  wire logic acc = psel && penable && pready;
  wire logic lc = paddr == `PLCUB_LINK_CONTROL_OFS;
  wire logic wr_lc = acc && pwrite && lc && pstrb[0];
  wire logic rd_lc = acc && !pwrite && lc;
  wire logic busy = ltssm_in_recovery || ltssm_in_config;
  wire logic no_bw = !bw_notify_capable_pin || upstream_port_pin;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_retrain_pulse: assert property (wr_lc && pwdata[5] |=> retrain_req)
    else $error("retrain request missing after retrain write");
  chk_retrain_single: assert property (retrain_req |=> !retrain_req)
    else $error("retrain request longer than one cycle");
  chk_tip_set: assert property (wr_lc && pwdata[5] && !upstream_port_pin
    && !$past(upstream_port_pin) |=> training_in_progress)
    else $error("training flag not set by retrain write");
  chk_ctl_zero_bits: assert property (rd_lc |-> prdata[5] == 1'b0
    && prdata[9:8] == 2'h0 && prdata[15:12] == 4'h0)
    else $error("fixed zero bit read as one");
  chk_apply_now: assert property (wr_lc && !busy |=>
    common_refclk_flag == $past(pwdata[6]) && extended_sync_enable == $past(pwdata[7]))
    else $error("field change not applied at once");
  chk_apply_later: assert property (wr_lc && busy && $past(busy) |=>
    $stable(common_refclk_flag) && $stable(extended_sync_enable))
    else $error("field change applied in current training");
  chk_irq_gated: assert property (rd_lc && prdata[11:10] == 2'h0 |-> !bw_irq)
    else $error("interrupt high with both enables clear");
  chk_strap_irq: assert property (no_bw && $past(no_bw, 5) |-> !bw_irq)
    else $error("interrupt high without notification support");

  cover property (retrain_req);
  cover property (bw_irq);
  cover property (wr_lc && busy);
endmodule : plcub_top_asserts

bind plcub_top plcub_top_asserts u_plcub_top_asserts (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .upstream_port_pin(upstream_port_pin), .bw_notify_capable_pin(bw_notify_capable_pin),
  .ltssm_in_recovery(ltssm_in_recovery), .ltssm_in_config(ltssm_in_config),
  .retrain_req(retrain_req), .common_refclk_flag(common_refclk_flag),
  .extended_sync_enable(extended_sync_enable),
  .training_in_progress(training_in_progress), .bw_irq(bw_irq)
);

`default_nettype wire
